// ==== prio_irq_map.svh ====
// register addresses, field positions, vectors and reset values of the interrupt unit
`ifndef PRIO_IRQ_MAP_SVH
`define PRIO_IRQ_MAP_SVH

// special-function byte addresses
`define ADDR_PEND_EXT 8'h2e
`define ADDR_PEND_LOW 8'h3c
`define ADDR_PEND_HIGH 8'h3d
`define ADDR_EN_LOW 8'h3a
`define ADDR_EN_HIGH 8'h3b
`define ADDR_EN_EXT 8'h2c

// field positions
`define MASTER_EN_BIT 0
`define EN_LOW_MSB 7
`define EN_LOW_LSB 4
`define EN_EXT_MSB 3
`define EN_EXT_LSB 0
`define EN_EXT_STORED_MSB 19
`define EN_EXT_STORED_LSB 16

// source positions
`define SRC_TRAP 5'h00
`define SRC_FETCH_GUARD 5'h02
`define SRC_WATCHDOG 5'h03
`define SRC_EXT0 5'h04
`define SRC_HIGH_FIRST 5'h10
`define SRC_FIRST_LATCH 2
`define SRC_FIRST_MASKABLE 4
`define SRC_LAST 23
`define SRC_COUNT 24

// vector generation: vector = top - 2 * source
`define VEC_TRAP 16'hfffc
`define VEC_LOW_TOP 16'hfffe
`define VEC_HIGH_TOP 16'hffde

// reset values
`define RST_BYTE 8'h00
`define RST_VEC 16'h0000
`define RST_IDX 5'h00
`define RST_BIT 1'b0

`endif

// ==== prio_irq_pkg.sv ====
// types shared by the interrupt unit
package prio_irq_pkg;

  typedef logic [23:0] src_vec_t;
  typedef logic [4:0] src_idx_t;
  typedef enum logic [0:0] {PRES_IDLE, PRES_OFFER} present_state_t;

endpackage : prio_irq_pkg

// ==== irq_priority_encoder.sv ====
// fixed-priority picker: the lowest request index wins
`timescale 1ns/1ps
`default_nettype none

module irq_priority_encoder #(
  parameter int N = 24,
  parameter int IW = 5
) (
  input wire logic [N-1:0] req,
  output logic valid,
  output logic [IW-1:0] idx
);

  always_comb begin
    valid = 1'b0;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        valid = 1'b1;
        idx = IW'(i);
      end
    end
  end

endmodule : irq_priority_encoder

`default_nettype wire

// ==== prioritised_interrupt_latch_unit.sv ====
// interrupt control unit: pending latches, enables, priority pick and vector offer to the cpu
//
// Behaviour
// - twenty sources besides reset; four internal traps are non-maskable, rest maskable.
// - nesting allowed; a higher request may interrupt a running lower service.
// - simultaneous requests taken in fixed hardware order, lowest position first; traps ranked the same way.
// - software and illegal-opcode traps: non-maskable, unlatched, one shared vector, level 2.
// - fetch-guard trap non-maskable, latch position 2, own vector, level 2.
// - watchdog trap non-maskable, latch position 3, own vector, level 2.
// - external input 0 needs master enable, its flag and the ext0 gate.
// - latched sources 5 to 19 each own a vector falling by two, except 16, which lies 0x22 below 15.
// - maskable request accepted only with master and individual enable both set.
// - a request sets its latch, which then asks service if enabled.
// - a latch clears as soon as the cpu accepts its interrupt.
// - reset clears every pending latch.
// - the two unlatched traps have no latch; every other source has one.
// - latches sit at three byte addresses, readable, zero written clears a bit.
// - writing one never sets a latch; only hardware requests set it.
// - reading the latches returns current request status for polling.
// - a converter-done latch is never cleared by the acceptance of another source.
// - fetch-guard and watchdog events reset unless their select bit is cleared.
// - acceptance saves then clears master enable; return restores the saved value.
// - individual enable flags gate their sources and reset to zero.
// - master enable is bit 0 of the low enable register, read/write, resets zero.
`timescale 1ns/1ps
`default_nettype none
`include "prio_irq_map.svh"

module prioritised_interrupt_latch_unit (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic [23:4] source_req,
  input wire logic fetch_guard_event,
  input wire logic watchdog_event,
  input wire logic fetch_guard_select,
  input wire logic watchdog_select,
  input wire logic ext0_gate,
  input wire logic soft_trap,
  input wire logic illegal_opcode_trap,
  input wire logic instr_boundary,
  input wire logic irq_ack,
  input wire logic reti,
  input wire logic reti_master_en,
  output logic irq_request,
  output logic [15:0] irq_vector,
  output logic [4:0] irq_source,
  output logic saved_master_enable,
  output logic master_irq_enable,
  output logic fetch_guard_reset_req,
  output logic watchdog_reset_req
);

  ////////////////////////////////////////////////////////////////////////////
  // decoding helpers

  function automatic prio_irq_pkg::src_vec_t onehot(input prio_irq_pkg::src_idx_t idx);
    onehot = '0;
    onehot[idx] = 1'b1;
  endfunction : onehot

  function automatic logic [15:0] vector_of(input prio_irq_pkg::src_idx_t idx);
    logic [15:0] twice;
    twice = {10'h000, idx, 1'b0};
    if (idx == `SRC_TRAP) begin
      vector_of = `VEC_TRAP;
    end else if (idx < `SRC_HIGH_FIRST) begin
      vector_of = `VEC_LOW_TOP - twice;
    end else begin
      vector_of = `VEC_HIGH_TOP - twice;
    end
  endfunction : vector_of

  ////////////////////////////////////////////////////////////////////////////
  // state

  prio_irq_pkg::src_vec_t pend_r;
  prio_irq_pkg::src_vec_t hw_set;
  prio_irq_pkg::src_vec_t sw_clr;
  prio_irq_pkg::src_vec_t ack_clr;
  prio_irq_pkg::src_vec_t enable_mask;
  prio_irq_pkg::src_vec_t eligible;
  prio_irq_pkg::present_state_t pres_r;
  logic [19:4] en_r;
  logic master_en_r;
  logic ack_take;
  logic win_valid;
  prio_irq_pkg::src_idx_t win_idx;
  logic wr_pend_ext;
  logic wr_pend_low;
  logic wr_pend_high;
  logic wr_en_low;
  logic wr_en_high;
  logic wr_en_ext;

  assign wr_pend_ext = sfr_wr && (sfr_addr == `ADDR_PEND_EXT);
  assign wr_pend_low = sfr_wr && (sfr_addr == `ADDR_PEND_LOW);
  assign wr_pend_high = sfr_wr && (sfr_addr == `ADDR_PEND_HIGH);
  assign wr_en_low = sfr_wr && (sfr_addr == `ADDR_EN_LOW);
  assign wr_en_high = sfr_wr && (sfr_addr == `ADDR_EN_HIGH);
  assign wr_en_ext = sfr_wr && (sfr_addr == `ADDR_EN_EXT);
  assign ack_take = irq_ack && (pres_r == prio_irq_pkg::PRES_OFFER);

  ////////////////////////////////////////////////////////////////////////////
  // set and clear terms of the pending latches

  always_comb begin
    hw_set = '0;
    // routed to a reset request while its select bit is still one
    hw_set[`SRC_FETCH_GUARD] = fetch_guard_event && !fetch_guard_select;
    hw_set[`SRC_WATCHDOG] = watchdog_event && !watchdog_select;
    hw_set[`SRC_LAST:`SRC_FIRST_MASKABLE] = source_req;
  end

  always_comb begin
    sw_clr = '0;
    // zero bits clear, one bits leave the latch alone
    if (wr_pend_low) begin
      sw_clr[7:0] = ~sfr_wdata;
    end
    if (wr_pend_high) begin
      sw_clr[15:8] = ~sfr_wdata;
    end
    if (wr_pend_ext) begin
      sw_clr[23:16] = ~sfr_wdata;
    end
  end

  // only the offered source is cleared, so a late converter-done request is never dropped
  assign ack_clr = ack_take ? onehot(irq_source) : '0;

  ////////////////////////////////////////////////////////////////////////////
  // pending latches: positions 0 and 1 do not exist

  genvar g;
  generate
    for (g = 0; g < `SRC_FIRST_LATCH; g++) begin : g_no_latch
      always_ff @(posedge clock) begin
        pend_r[g] <= `RST_BIT;
      end
    end
    for (g = `SRC_FIRST_LATCH; g <= `SRC_LAST; g++) begin : g_latch
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          pend_r[g] <= `RST_BIT;
        end else if (hw_set[g]) begin
          pend_r[g] <= 1'b1;
        end else if (sw_clr[g] || ack_clr[g]) begin
          pend_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // individual enables and master enable

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      en_r <= '0;
    end else begin
      if (wr_en_low) begin
        en_r[`EN_LOW_MSB:`EN_LOW_LSB] <= sfr_wdata[`EN_LOW_MSB:`EN_LOW_LSB];
      end
      if (wr_en_high) begin
        en_r[15:8] <= sfr_wdata;
      end
      if (wr_en_ext) begin
        en_r[`EN_EXT_STORED_MSB:`EN_EXT_STORED_LSB] <= sfr_wdata[`EN_EXT_MSB:`EN_EXT_LSB];
      end
    end
  end

  // acceptance beats return, return beats a software write
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      master_en_r <= `RST_BIT;
    end else if (ack_take) begin
      master_en_r <= 1'b0;
    end else if (reti) begin
      master_en_r <= reti_master_en;
    end else if (wr_en_low) begin
      master_en_r <= sfr_wdata[`MASTER_EN_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      saved_master_enable <= `RST_BIT;
    end else if (ack_take) begin
      saved_master_enable <= master_en_r;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      master_irq_enable <= `RST_BIT;
    end else begin
      master_irq_enable <= ack_take ? 1'b0 :
        (reti ? reti_master_en : (wr_en_low ? sfr_wdata[`MASTER_EN_BIT] : master_en_r));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // eligibility and priority pick

  always_comb begin
    enable_mask = '0;
    enable_mask[`SRC_TRAP] = 1'b1;
    enable_mask[`SRC_FETCH_GUARD] = 1'b1;
    enable_mask[`SRC_WATCHDOG] = 1'b1;
    // reserved sources 20..23 have no stored enable and never win
    enable_mask[19:4] = en_r & {16{master_en_r}};
    enable_mask[`SRC_EXT0] = master_en_r && en_r[`SRC_FIRST_MASKABLE] && ext0_gate;
  end

  always_comb begin
    eligible = pend_r & enable_mask;
    eligible[`SRC_TRAP] = soft_trap || illegal_opcode_trap;
  end

  // no in-service blocking: once software re-enables, any enabled source may nest
  irq_priority_encoder #(
    .N(`SRC_COUNT),
    .IW(5)
  ) u_pick (
    .req(eligible),
    .valid(win_valid),
    .idx(win_idx)
  );

  ////////////////////////////////////////////////////////////////////////////
  // offer to the cpu

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pres_r <= prio_irq_pkg::PRES_IDLE;
      irq_request <= `RST_BIT;
      irq_vector <= `RST_VEC;
      irq_source <= `RST_IDX;
    end else if (ack_take) begin
      pres_r <= prio_irq_pkg::PRES_IDLE;
      irq_request <= 1'b0;
    end else if (instr_boundary) begin
      irq_request <= win_valid;
      pres_r <= win_valid ? prio_irq_pkg::PRES_OFFER : prio_irq_pkg::PRES_IDLE;
      if (win_valid) begin
        irq_vector <= vector_of(win_idx);
        irq_source <= win_idx;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trap events routed to reset

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fetch_guard_reset_req <= `RST_BIT;
      watchdog_reset_req <= `RST_BIT;
    end else begin
      fetch_guard_reset_req <= fetch_guard_event && fetch_guard_select;
      watchdog_reset_req <= watchdog_event && watchdog_select;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read port, unmapped reads give zero

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sfr_rdata <= `RST_BYTE;
    end else if (sfr_rd) begin
      unique case (sfr_addr)
        `ADDR_PEND_LOW: sfr_rdata <= pend_r[7:0];
        `ADDR_PEND_HIGH: sfr_rdata <= pend_r[15:8];
        `ADDR_PEND_EXT: sfr_rdata <= pend_r[23:16];
        `ADDR_EN_LOW: sfr_rdata <= {en_r[`EN_LOW_MSB:`EN_LOW_LSB], 3'b000, master_en_r};
        `ADDR_EN_HIGH: sfr_rdata <= en_r[15:8];
        `ADDR_EN_EXT: sfr_rdata <= {4'h0, en_r[`EN_EXT_STORED_MSB:`EN_EXT_STORED_LSB]};
        default: sfr_rdata <= `RST_BYTE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  reset_clears_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(rst_n) |-> (pend_r == '0) && !master_en_r && (en_r == '0))
    else $error("latches or enables not zero after reset");

  one_never_sets_a: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_pend_low && (hw_set[7:0] == 8'h00)) |=> ((pend_r[7:0] & ~$past(pend_r[7:0])) == 8'h00))
    else $error("software write set a latch");

  zero_clears_a: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_pend_high && !sfr_wdata[0] && !hw_set[8]) |=> !pend_r[8])
    else $error("written zero did not clear latch");

  ack_clears_a: assert property (@(posedge clock) disable iff (!rst_n)
    (ack_take && (irq_source >= `SRC_FETCH_GUARD) && !hw_set[irq_source]) |=> !pend_r[$past(irq_source)])
    else $error("accepted latch not cleared");

  set_wins_a: assert property (@(posedge clock) disable iff (!rst_n)
    hw_set[9] |=> pend_r[9])
    else $error("hardware request lost");

  master_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
    ($rose(irq_request) && (irq_source >= `SRC_EXT0)) |-> $past(master_en_r))
    else $error("maskable offered with master enable off");

  ext0_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
    ($rose(irq_request) && (irq_source == `SRC_EXT0)) |-> $past(ext0_gate) && $past(en_r[`SRC_FIRST_MASKABLE]))
    else $error("ext0 offered without its gates");

  master_save_a: assert property (@(posedge clock) disable iff (!rst_n)
    ack_take |=> ((!master_en_r && (saved_master_enable == $past(master_en_r)))
      and ((!reti && !wr_en_low) |=> !master_en_r)))
    else $error("master enable not saved and cleared");

  reti_restore_a: assert property (@(posedge clock) disable iff (!rst_n)
    (reti && !ack_take) |=> (master_en_r == $past(reti_master_en)))
    else $error("return did not restore master enable");

  vector_match_a: assert property (@(posedge clock) disable iff (!rst_n)
    irq_request |-> ((irq_vector + {10'h000, irq_source, 1'b0}) ==
      ((irq_source == `SRC_TRAP) ? `VEC_TRAP : ((irq_source < `SRC_HIGH_FIRST) ? `VEC_LOW_TOP : `VEC_HIGH_TOP))))
    else $error("offered vector does not match source");

  top_choice_a: assert property (@(posedge clock) disable iff (!rst_n)
    (instr_boundary && !ack_take && eligible[`SRC_FETCH_GUARD] && !eligible[`SRC_TRAP])
      |=> irq_source == `SRC_FETCH_GUARD)
    else $error("fetch guard not chosen first");

  trap_route_a: assert property (@(posedge clock) disable iff (!rst_n)
    (watchdog_event && watchdog_select) |=> watchdog_reset_req && !($rose(pend_r[`SRC_WATCHDOG])))
    else $error("watchdog event not routed to reset");

endmodule : prioritised_interrupt_latch_unit

`default_nettype wire

// ==== cpu_core_model.sv ====
// behavioural cpu core: instruction boundaries, acceptance and return
`timescale 1ns/1ps
`default_nettype none

module cpu_core_model (
  input wire logic clock,
  input wire logic irq_request,
  input wire logic [15:0] irq_vector,
  input wire logic [4:0] irq_source,
  output logic instr_boundary,
  output logic irq_ack,
  output logic reti,
  output logic reti_master_en,
  output logic soft_trap,
  output logic illegal_opcode_trap
);
  initial begin
    instr_boundary = 1'b0;
    irq_ack = 1'b0;
    reti = 1'b0;
    reti_master_en = 1'b0;
    soft_trap = 1'b0;
    illegal_opcode_trap = 1'b0;
  end

  //////////////////////////////////////////////////////////////////
  // one boundary, then accept a standing offer after a few idle cycles
  task automatic serve(input logic [1:0] trap, input int idle, output logic got, output logic [15:0] vec,
                       output logic [4:0] src);
    @(posedge clock);
    #1;
    instr_boundary = 1'b1;
    soft_trap = trap[0];
    illegal_opcode_trap = trap[1];
    @(posedge clock);
    #1;
    instr_boundary = 1'b0;
    soft_trap = 1'b0;
    illegal_opcode_trap = 1'b0;
    got = irq_request;
    vec = irq_vector;
    src = irq_source;
    repeat (idle) @(posedge clock);
    if (got === 1'b1) begin
      #1;
      irq_ack = 1'b1;
      @(posedge clock);
      #1;
      irq_ack = 1'b0;
    end
  endtask : serve

  // return from interrupt with the stacked master enable
  task automatic ret(input logic en);
    @(posedge clock);
    #1;
    reti = 1'b1;
    reti_master_en = en;
    @(posedge clock);
    #1;
    reti = 1'b0;
  endtask : ret
endmodule : cpu_core_model
`default_nettype wire

// ==== prioritised_interrupt_latch_unit_tb.sv ====
// self-checking testbench of the interrupt unit
`timescale 1ns/1ps
`default_nettype none

module prioritised_interrupt_latch_unit_tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic [23:4] source_req = '0;
  logic fg_ev = 1'b0;
  logic wd_ev = 1'b0;
  logic fg_sel = 1'b0;
  logic wd_sel = 1'b0;
  logic ext0_gate = 1'b0;
  logic soft_trap, illegal_opcode_trap, instr_boundary, irq_ack, reti, reti_master_en;
  logic irq_request, saved_master_enable, master_irq_enable, fg_rst, wd_rst;
  logic [15:0] irq_vector;
  logic [4:0] irq_source;
  int miscompares = 0;
  int compares = 0;

  always #20 clock = ~clock;

  prioritised_interrupt_latch_unit i_dut (.clock(clock), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .source_req(source_req),
    .fetch_guard_event(fg_ev), .watchdog_event(wd_ev), .fetch_guard_select(fg_sel), .watchdog_select(wd_sel),
    .ext0_gate(ext0_gate), .soft_trap(soft_trap), .illegal_opcode_trap(illegal_opcode_trap),
    .instr_boundary(instr_boundary), .irq_ack(irq_ack), .reti(reti), .reti_master_en(reti_master_en),
    .irq_request(irq_request), .irq_vector(irq_vector), .irq_source(irq_source),
    .saved_master_enable(saved_master_enable), .master_irq_enable(master_irq_enable),
    .fetch_guard_reset_req(fg_rst), .watchdog_reset_req(wd_rst));

  cpu_core_model i_cpu (.clock(clock), .irq_request(irq_request), .irq_vector(irq_vector),
    .irq_source(irq_source), .instr_boundary(instr_boundary), .irq_ack(irq_ack), .reti(reti),
    .reti_master_en(reti_master_en), .soft_trap(soft_trap), .illegal_opcode_trap(illegal_opcode_trap));

  //////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    @(posedge clock);
    #1;
    sfr_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    #1;
    sfr_rd = 1'b1;
    sfr_addr = a;
    @(posedge clock);
    #1;
    sfr_rd = 1'b0;
    chk($sformatf("register %h", a), {8'h00, exp}, {8'h00, sfr_rdata});
  endtask : rd

  task automatic pulse(input logic [19:0] m, input logic fg, input logic wd);
    @(posedge clock);
    #1;
    source_req = m;
    fg_ev = fg;
    wd_ev = wd;
    @(posedge clock);
    #1;
    source_req = '0;
    fg_ev = 1'b0;
    wd_ev = 1'b0;
  endtask : pulse

  task automatic offer(input logic [1:0] trap, input logic eg, input logic [15:0] ev, input logic [4:0] es);
    logic g;
    logic [15:0] v;
    logic [4:0] s;
    i_cpu.serve(trap, 2, g, v, s);
    chk("offer", {15'h0000, eg}, {15'h0000, g});
    if (eg) begin
      chk("vector", ev, v);
      chk("source", {11'h000, es}, {11'h000, s});
      chk("offer after ack", 16'h0000, {15'h0000, irq_request});
    end
  endtask : offer

  //////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    stop_test();
  end

  initial begin
    repeat (12) @(posedge clock);
    #1;
    rst_n = 1'b1;
    chk("request after reset", 16'h0000, {15'h0000, irq_request});
    rd(8'h2e, 8'h00);
    rd(8'h3c, 8'h00);
    rd(8'h3d, 8'h00);
    rd(8'h3a, 8'h00);
    rd(8'h3b, 8'h00);
    rd(8'h2c, 8'h00);
    // every latched source at once, traps routed to their latches
    pulse(20'hfffff, 1'b1, 1'b1);
    rd(8'h3c, 8'hfc);
    rd(8'h3d, 8'hff);
    rd(8'h2e, 8'hff);
    wr(8'h3c, 8'h0c);
    wr(8'h3d, 8'h00);
    wr(8'h2e, 8'h00);
    rd(8'h3c, 8'h0c);
    rd(8'h3d, 8'h00);
    wr(8'h3d, 8'hff);
    rd(8'h3d, 8'h00);
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h00);
    // traps with master enable off
    offer(2'b00, 1'b1, 16'hfffa, 5'd2);
    rd(8'h3c, 8'h08);
    offer(2'b00, 1'b1, 16'hfff8, 5'd3);
    offer(2'b01, 1'b1, 16'hfffc, 5'd0);
    offer(2'b10, 1'b1, 16'hfffc, 5'd0);
    rd(8'h3c, 8'h00);
    offer(2'b00, 1'b0, 16'h0000, 5'd0);
    // maskable gating
    pulse(20'h00002, 1'b0, 1'b0);
    wr(8'h3a, 8'h20);
    offer(2'b00, 1'b0, 16'h0000, 5'd0);
    wr(8'h3a, 8'h01);
    offer(2'b00, 1'b0, 16'h0000, 5'd0);
    wr(8'h3a, 8'h21);
    offer(2'b00, 1'b1, 16'hfff4, 5'd5);
    chk("master after ack", 16'h0000, {15'h0000, master_irq_enable});
    chk("saved master", 16'h0001, {15'h0000, saved_master_enable});
    i_cpu.ret(1'b1);
    chk("master after return", 16'h0001, {15'h0000, master_irq_enable});
    pulse(20'h00001, 1'b0, 1'b0);
    wr(8'h3a, 8'h11);
    rd(8'h3a, 8'h11);
    offer(2'b00, 1'b0, 16'h0000, 5'd0);
    #1;
    ext0_gate = 1'b1;
    offer(2'b00, 1'b1, 16'hfff6, 5'd4);
    // one vector per source
    wr(8'h3a, 8'hf1);
    wr(8'h3b, 8'hff);
    wr(8'h2c, 8'hff);
    rd(8'h2c, 8'h0f);
    for (int n = 5; n < 20; n++) begin
      pulse(20'h00001 << (n - 4), 1'b0, 1'b0);
      offer(2'b00, 1'b1, (n < 16 ? 16'hfffe : 16'hffde) - 16'(2 * n), 5'(n));
      i_cpu.ret(1'b1);
    end
    // simultaneous requests and nesting
    pulse(20'h00024, 1'b0, 1'b0);
    offer(2'b00, 1'b1, 16'hfff2, 5'd6);
    offer(2'b00, 1'b0, 16'h0000, 5'd0);
    wr(8'h3a, 8'hf1);
    offer(2'b00, 1'b1, 16'hffec, 5'd9);
    i_cpu.ret(1'b1);
    pulse(20'h00808, 1'b0, 1'b0);
    offer(2'b00, 1'b1, 16'hfff0, 5'd7);
    rd(8'h3d, 8'h80);
    i_cpu.ret(1'b1);
    offer(2'b00, 1'b1, 16'hffe0, 5'd15);
    // trap events routed to reset requests
    fg_sel = 1'b1;
    wd_sel = 1'b1;
    pulse(20'h00000, 1'b1, 1'b1);
    chk("guard reset request", 16'h0001, {15'h0000, fg_rst});
    chk("watchdog reset request", 16'h0001, {15'h0000, wd_rst});
    @(posedge clock);
    #1;
    chk("reset request end", 16'h0000, {14'h0000, fg_rst, wd_rst});
    rd(8'h3c, 8'h00);
    // reset in mid-run with a latch and enables set, master enable off since the last acceptance
    pulse(20'h00002, 1'b0, 1'b0);
    rd(8'h3c, 8'h20);
    @(posedge clock);
    #1;
    rst_n = 1'b0;
    repeat (12) @(posedge clock);
    #1;
    rst_n = 1'b1;
    chk("request after second reset", 16'h0000, {15'h0000, irq_request});
    rd(8'h3c, 8'h00);
    rd(8'h3a, 8'h00);
    rd(8'h3b, 8'h00);
    chk("master after second reset", 16'h0000, {15'h0000, master_irq_enable});
    stop_test();
  end
endmodule : prioritised_interrupt_latch_unit_tb
`default_nettype wire
